// *** src/irie_pkg.sv ***
// Package for the infrared interrupt enable and identification block.
package irie_pkg;
   // Register indices and byte addresses; a byte address is four times its index.
   localparam logic [7:0] IDX_SOURCE = 8'h02;
   localparam logic [7:0] IDX_ENABLE = 8'h01;
   localparam logic [7:0] ADDR_ENABLE = 8'h04;
   localparam logic [7:0] ADDR_SOURCE = 8'h08;
   localparam logic [7:0] ADDR_FIFO_CTRL = 8'h10;
   localparam logic [7:0] ADDR_MODE = 8'h14;
   localparam logic [7:0] ADDR_STATUS = 8'h18;
   localparam logic [7:0] ADDR_MASK = 8'h1c;
   // Bit positions.
   localparam int B_RX_THR = 0;
   localparam int B_TX_THR = 1;
   localparam int B_LAST_READ = 2;
   localparam int B_OVERRUN = 3;
   localparam int B_SF_THR = 4;
   localparam int B_UNDERRUN = 5;
   localparam int B_COUNT_DONE = 6;
   localparam int B_EOF = 7;
   localparam int B_TIMEOUT = 2;
   localparam int B_DMA_SEL = 3;
   // Reset values.
   localparam logic [7:0] SOURCE_PIO_RESET = 8'h02;
   localparam logic [7:0] ZERO8 = 8'h00;
   // Enable bits that consumer mode honours; the others are forced off there.
   localparam logic [7:0] CONSUMER_MASK = 8'h2b;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // Time-out: 1 ms at 10 MHz.
   localparam int CLK_HZ = 10000000;
   localparam int TIMEOUT_US = 1000;
   localparam int TIMEOUT_CYCLES = (CLK_HZ / 1000000) * TIMEOUT_US;
   typedef enum logic [1:0] {MODE_CONSUMER, MODE_FAST} irie_mode_t;
   // Event inputs from the FIFO and framing logic.
   typedef struct packed {
      logic rx_at_thr;
      logic tx_below_thr;
      logic last_byte_read;
      logic rx_overrun;
      logic overrun_serviced;
      logic tx_underrun;
      logic underrun_serviced;
      logic eof_detected;
      logic frame_received;
      logic sf_at_thr;
      logic sf_read;
      logic transfer_count_done;
   } irie_ev_t;
endpackage

// *** src/irie_top.sv ***
// Interrupt enable and identification logic with an AXI4-Lite register slave.
//
// Register access over AXI4-Lite is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module irie_top #(
   parameter int TIMEOUT_COUNT = irie_pkg::TIMEOUT_CYCLES
)
(
   // Clock and reset.
   input wire logic clk,
   input wire logic rst,
   // AXI4-Lite slave.
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Events from the FIFO and framing logic.
   input wire irie_pkg::irie_ev_t ev,
   // Outputs.
   output logic rx_hold,
   output logic irq_ident,
   output logic irq
);
   ////////////////////////////////////////////////////////////////////////////
   logic [7:0] interrupt_enable_reg;
   logic [7:0] fifo_control_reg;
   logic consumer_mode;
   logic [7:0] status;
   logic [7:0] mask;
   logic last_read, overrun, underrun, eof_flag, sf_timeout, count_done_flag, sf_thr_flag;
   logic [$clog2(TIMEOUT_COUNT+1)-1:0] gap_cnt;
   logic gap_run;
   logic aw_held, w_held;
   logic [7:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;

   ////////////////////////////////////////////////////////////////////////////
   // Write channel: address and data captured in either order.
   // Only byte lane 0 holds a register; a write without it is answered but changes nothing.
   wire aw_take = s_axi_awvalid && s_axi_awready;
   wire w_take = s_axi_wvalid && s_axi_wready;
   wire aw_have = aw_held || aw_take;
   wire w_have = w_held || w_take;
   wire [7:0] wr_addr = aw_held ? aw_addr : s_axi_awaddr;
   wire [31:0] wr_data = w_held ? w_data : s_axi_wdata;
   wire wr_lane0 = w_held ? w_strb[0] : s_axi_wstrb[0];
   wire do_write = aw_have && w_have && !s_axi_bvalid;
   wire wr_en = do_write && wr_lane0;
   wire wr_enable = wr_en && (wr_addr == irie_pkg::ADDR_ENABLE);
   wire wr_fifo_ctrl = wr_en && (wr_addr == irie_pkg::ADDR_FIFO_CTRL);
   wire wr_mode = wr_en && (wr_addr == irie_pkg::ADDR_MODE);
   wire wr_status = wr_en && (wr_addr == irie_pkg::ADDR_STATUS);
   wire wr_mask = wr_en && (wr_addr == irie_pkg::ADDR_MASK);
   wire wr_known = (wr_addr == irie_pkg::ADDR_ENABLE) || (wr_addr == irie_pkg::ADDR_FIFO_CTRL)
      || (wr_addr == irie_pkg::ADDR_MODE) || (wr_addr == irie_pkg::ADDR_STATUS)
      || (wr_addr == irie_pkg::ADDR_MASK) || (wr_addr == irie_pkg::ADDR_SOURCE);

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= irie_pkg::ZERO8;
         w_data <= 32'h0;
         w_strb <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= irie_pkg::RESP_OKAY;
      end
      else
      begin
         if (aw_take)
            aw_addr <= s_axi_awaddr;
         if (w_take)
         begin
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         aw_held <= do_write ? 1'b0 : aw_have;
         w_held <= do_write ? 1'b0 : w_have;
         // The response stays up until the master takes it; new requests wait behind it.
         if (do_write)
         begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_known ? irie_pkg::RESP_OKAY : irie_pkg::RESP_SLVERR;
         end
         else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   // Ready is a register that shows what the held and response flags become at this edge, so it
   // always agrees with them and no handshake is taken twice.
   wire next_aw_held = do_write ? 1'b0 : aw_have;
   wire next_w_held = do_write ? 1'b0 : w_have;
   wire next_bvalid = do_write || (s_axi_bvalid && !s_axi_bready);

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
      end
      else
      begin
         s_axi_awready <= !next_aw_held && !next_bvalid;
         s_axi_wready <= !next_w_held && !next_bvalid;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Control registers.
   wire dma_mode = fifo_control_reg[irie_pkg::B_DMA_SEL];

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         interrupt_enable_reg <= irie_pkg::ZERO8;
         fifo_control_reg <= irie_pkg::ZERO8;
         consumer_mode <= 1'b0;
         mask <= irie_pkg::ZERO8;
      end
      else
      begin
         if (wr_enable)
            interrupt_enable_reg <= wr_data[7:0];
         if (wr_fifo_ctrl)
            fifo_control_reg <= wr_data[7:0];
         // Consumer-remote operation overrides both fast layouts for irq_ident while it is selected; source reads still see the fast layout.
         if (wr_mode)
            consumer_mode <= wr_data[0];
         if (wr_mask)
            mask <= wr_data[7:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read channel and identification layouts.
   wire rd_take = s_axi_arvalid && s_axi_arready;
   wire rd_source = rd_take && (s_axi_araddr == irie_pkg::ADDR_SOURCE);

   wire [7:0] interrupt_source_pio_layout = {eof_flag, 1'b0, underrun, 1'b0, overrun, last_read,
      ev.tx_below_thr, ev.rx_at_thr};
   // The DMA layout is read-only; its status FIFO flags wait for a status FIFO read.
   wire [7:0] interrupt_source_reg = {1'b0, count_done_flag, underrun, sf_thr_flag, 1'b0, sf_timeout,
      2'b00};
   // Fast-mode reads see the layout that the DMA select bit picks.
   wire [7:0] source_view = dma_mode ? interrupt_source_reg : interrupt_source_pio_layout;

   // Consumer mode keeps only the documented enable bits and forces the others off.
   wire [7:0] en_eff = consumer_mode ? (interrupt_enable_reg & irie_pkg::CONSUMER_MASK)
      : interrupt_enable_reg;
   wire [7:0] cons_src = {2'b00, underrun, 1'b0, overrun, 1'b0, ev.tx_below_thr, ev.rx_at_thr};
   wire [7:0] active_src = consumer_mode ? cons_src : source_view;
   // Every interrupt source passes through its enable bit before it can reach irq_ident.
   wire any_pending = |(active_src & en_eff);

   // Sticky event bits for the status register.
   wire [7:0] ev_vec = {ev.eof_detected, ev.transfer_count_done, ev.tx_underrun, ev.sf_at_thr,
      ev.rx_overrun, sf_timeout, ev.tx_below_thr, ev.rx_at_thr};

   logic [31:0] rd_mux;
   always_comb
   begin
      case (s_axi_araddr)
         irie_pkg::ADDR_ENABLE: rd_mux = {24'h0, interrupt_enable_reg};
         irie_pkg::ADDR_SOURCE: rd_mux = {24'h0, source_view};
         irie_pkg::ADDR_FIFO_CTRL: rd_mux = {24'h0, fifo_control_reg};
         irie_pkg::ADDR_MODE: rd_mux = {31'h0, consumer_mode};
         irie_pkg::ADDR_STATUS: rd_mux = {24'h0, status};
         irie_pkg::ADDR_MASK: rd_mux = {24'h0, mask};
         default: rd_mux = 32'h0;
      endcase
   end
   // Unmapped addresses answer with an error and read back zero.
   wire rd_known = (s_axi_araddr == irie_pkg::ADDR_ENABLE) || (s_axi_araddr == irie_pkg::ADDR_SOURCE)
      || (s_axi_araddr == irie_pkg::ADDR_FIFO_CTRL) || (s_axi_araddr == irie_pkg::ADDR_MODE)
      || (s_axi_araddr == irie_pkg::ADDR_STATUS) || (s_axi_araddr == irie_pkg::ADDR_MASK);

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= irie_pkg::RESP_OKAY;
         s_axi_arready <= 1'b1;
      end
      else if (rd_take)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_mux;
         s_axi_rresp <= rd_known ? irie_pkg::RESP_OKAY : irie_pkg::RESP_SLVERR;
         s_axi_arready <= 1'b0;
      end
      else if (s_axi_rready)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pending flags; a set in the same cycle as a clear wins.
   // A time-out flags once per gap; a silent line does not flag again every millisecond.
   wire gap_hit = gap_run && (gap_cnt == ($clog2(TIMEOUT_COUNT+1))'(TIMEOUT_COUNT - 1));
   wire rd_pio = rd_source && !dma_mode;

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         last_read <= 1'b0;
         overrun <= 1'b0;
         underrun <= 1'b0;
         eof_flag <= 1'b0;
         sf_timeout <= 1'b0;
         count_done_flag <= 1'b0;
         sf_thr_flag <= 1'b0;
         gap_cnt <= '0;
         gap_run <= 1'b0;
      end
      else
      begin
         // Only a read in the programmed-I/O layout clears the frame flags.
         last_read <= ev.last_byte_read || (last_read && !rd_pio);
         eof_flag <= ev.eof_detected || (eof_flag && !rd_pio);
         overrun <= ev.rx_overrun || (overrun && !ev.overrun_serviced);
         underrun <= ev.tx_underrun || (underrun && !ev.underrun_serviced);
         sf_timeout <= gap_hit || (sf_timeout && !ev.sf_read);
         count_done_flag <= ev.transfer_count_done || (count_done_flag && !ev.sf_read);
         sf_thr_flag <= ev.sf_at_thr || (sf_thr_flag && !ev.sf_read);
         // Each received frame restarts the count, so the time-out measures the gap alone.
         if (ev.frame_received)
         begin
            gap_run <= 1'b1;
            gap_cnt <= '0;
         end
         else if (gap_hit)
            gap_run <= 1'b0;
         else if (gap_run)
            gap_cnt <= gap_cnt + 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Sticky status, write one to clear, and outputs.
   wire [7:0] status_clr = wr_status ? wr_data[7:0] : irie_pkg::ZERO8;
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         status <= irie_pkg::ZERO8;
         rx_hold <= 1'b0;
         irq_ident <= 1'b0;
         irq <= 1'b0;
      end
      else
      begin
         status <= ev_vec | (status & ~status_clr);
         // The hold rises with the overrun flag itself, so no further byte slips in behind it.
         rx_hold <= ev.rx_overrun || (overrun && !ev.overrun_serviced);
         // The identification interrupt follows the active layout; irq follows status and mask.
         irq_ident <= any_pending;
         irq <= |(status & mask);
      end
   end
endmodule // irie_top
`default_nettype wire

// *** tb/irie_props.sv ***
// Concurrent checks on the register bus and the overrun hold of the interrupt block.
`timescale 1ns/1ps
`default_nettype none
module irie_props (
   // Clock and reset.
   input wire logic clk,
   input wire logic rst,
   // Register bus.
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Events and hold.
   input wire irie_pkg::irie_ev_t ev,
   input wire logic rx_hold
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // The hold may lag the flag by a register, so one or two cycles are allowed.
   hold_set_a: assert property (ev.rx_overrun |-> ##[1:2] rx_hold)
      else $error("overrun did not hold reception");
   hold_keep_a: assert property (rx_hold && !ev.overrun_serviced && !$past(ev.overrun_serviced) |=> rx_hold)
      else $error("hold dropped without service");
   hold_clear_a: assert property (ev.overrun_serviced && !ev.rx_overrun ##1 !ev.rx_overrun |-> ##[0:1] !rx_hold)
      else $error("hold kept after service");
   bvalid_keep_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response dropped early");
   rdata_keep_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data changed while waiting");
   write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
      else $error("write response late");
   read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read response late");
   read_gate_a: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read address taken while busy");
   unmapped_read_a: assert property (s_axi_arvalid && s_axi_arready &&
      !(s_axi_araddr inside {8'h04, 8'h08, 8'h10, 8'h14, 8'h18, 8'h1c})
      |=> s_axi_rresp == irie_pkg::RESP_SLVERR && s_axi_rdata == 32'h0)
      else $error("unmapped read not refused");
endmodule // irie_props
bind irie_top irie_props irie_props_inst (.*);
`default_nettype wire

// *** tb/tb_top.sv ***
// Self-checking bench for the infrared interrupt enable and identification block.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, v;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd_data;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, rx_hold, irq_ident, irq;
   logic [1:0] s_axi_bresp, s_axi_rresp, rd_resp;
   // Transmit level starts below threshold, as an empty FIFO would report.
   irie_pkg::irie_ev_t ev = 12'h400;
   int n_errors = 0, cmp_count = 0, cycles = 0;
   irie_top #(.TIMEOUT_COUNT(20)) irie_top_inst (.*);
   always #50 clk = ~clk;
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         n_errors++;
         report_and_stop();
      end
   end
   ////////////////////////////////////////////////////////////////
   function automatic logic [31:0] pio(logic rx, tx, lb, ov, ur, eof);
      return {24'h0, eof, 1'b0, ur, 1'b0, ov, lb, tx, rx};
   endfunction
   function automatic logic [31:0] dma(logic to, sf, ur, cd);
      return {24'h0, 1'b0, cd, ur, sf, 1'b0, to, 2'b0};
   endfunction
   task automatic chk(string n, logic [31:0] e, logic [31:0] g);
      cmp_count++;
      if (g !== e)
      begin
         n_errors++;
         $display("[ERR] %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic wr(logic [7:0] a, logic [7:0] d);
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      forever
      begin
         @(posedge clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid)
         begin
            s_axi_bready <= 1'b0;
            break;
         end
      end
   endtask
   task automatic rd(logic [7:0] a);
      @(posedge clk);
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'h3;
      forever
      begin
         @(posedge clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid)
         begin
            s_axi_rready <= 1'b0;
            rd_data = s_axi_rdata;
            rd_resp = s_axi_rresp;
            break;
         end
      end
   endtask
   task automatic rchk(string n, logic [7:0] a, logic [31:0] e);
      rd(a);
      chk(n, e, rd_data);
   endtask
   // Event masks follow the struct order, transfer-count-done in bit 0.
   task automatic pulse(logic [11:0] m);
      @(posedge clk) ev <= ev | m;
      @(posedge clk) ev <= ev & ~m;
      repeat (2) @(posedge clk);
   endtask
   task automatic report_and_stop();
      $display("errors %0d compares %0d", n_errors, cmp_count);
      if (n_errors == 0 && cmp_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////
   initial
   begin
      void'($urandom(32'h022f));
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      rchk("enable", 8'h04, 0);
      rchk("ident", 8'h08, pio(0, 1, 0, 0, 0, 0));
      chk("irq", 0, irq);
      repeat (4)
      begin
         v = 8'($urandom);
         wr(8'h04, v);
         rchk("enable", 8'h04, v);
      end
      ev.rx_at_thr <= 1'b1;
      ev.tx_below_thr <= 1'b0;
      pulse(12'h350);
      rchk("ident", 8'h08, pio(1, 0, 1, 1, 1, 1));
      chk("rx_hold", 1, rx_hold);
      rchk("ident", 8'h08, pio(1, 0, 0, 1, 1, 0));
      pulse(12'h0a0);
      rchk("ident", 8'h08, pio(1, 0, 0, 0, 0, 0));
      chk("rx_hold", 0, rx_hold);
      wr(8'h04, 8'h84);
      pulse(12'h010);
      chk("irq_ident", 1, irq_ident);
      rd(8'h08);
      pulse(12'h200);
      chk("irq_ident", 1, irq_ident);
      rd(8'h08);
      repeat (2) @(posedge clk);
      chk("irq_ident", 0, irq_ident);
      wr(8'h04, 8'h00);
      wr(8'h10, 8'h08);
      ev.tx_below_thr <= 1'b1;
      pulse(12'h005);
      pulse(12'h008);
      rchk("ident", 8'h08, dma(0, 1, 0, 1));
      repeat (20) @(posedge clk);
      pulse(12'h040);
      rchk("ident", 8'h08, dma(1, 1, 1, 1));
      rchk("ident", 8'h08, dma(1, 1, 1, 1));
      wr(8'h04, 8'h54);
      repeat (2) @(posedge clk);
      chk("irq_ident", 1, irq_ident);
      pulse(12'h002);
      rchk("ident", 8'h08, dma(0, 0, 1, 0));
      chk("irq_ident", 0, irq_ident);
      wr(8'h04, 8'h20);
      repeat (2) @(posedge clk);
      chk("irq_ident", 1, irq_ident);
      pulse(12'h020);
      rchk("ident", 8'h08, 0);
      chk("irq_ident", 0, irq_ident);
      wr(8'h10, 8'h00);
      wr(8'h14, 8'h01);
      ev.rx_at_thr <= 1'b0;
      wr(8'h04, 8'h02);
      repeat (2) @(posedge clk);
      chk("irq_ident", 1, irq_ident);
      ev.tx_below_thr <= 1'b0;
      wr(8'h04, 8'h29);
      pulse(12'h210);
      chk("irq_ident", 0, irq_ident);
      ev.rx_at_thr <= 1'b1;
      repeat (3) @(posedge clk);
      chk("irq_ident", 1, irq_ident);
      ev.rx_at_thr <= 1'b0;
      wr(8'h04, 8'h08);
      pulse(12'h100);
      chk("irq_ident", 1, irq_ident);
      pulse(12'h080);
      chk("irq_ident", 0, irq_ident);
      wr(8'h18, 8'hff);
      rchk("status", 8'h18, 0);
      wr(8'h1c, 8'h40);
      pulse(12'h001);
      chk("irq", 1, irq);
      rchk("status", 8'h18, 32'h40);
      wr(8'h18, 8'h40);
      repeat (2) @(posedge clk);
      chk("irq", 0, irq);
      rd(8'h0c);
      chk("rresp", irie_pkg::RESP_SLVERR, rd_resp);
      report_and_stop();
   end
endmodule // tb_top
`default_nettype wire
